//--- logic/ldd_dimmer.sv
/*
 * Two-channel PWM dimming processor with shared power derating.
 * Assumes an Avalon-MM master with waitrequest, asynchronous pin
 * inputs, and a battery level code from an outside converter.
 */
// The register addresses and the Avalon-MM register port were chosen for this implementation.
// What this block does
// - Each channel rebuilds its own buck enable PWM.
// - Output frequency is input frequency times multiplier.
// - Output duty is input duty times both factors.
// - Duty factor is (255 - code) / 255.
// - Derating set automatically, shared by both channels.
// - Per channel duty code, default at start, writable.
// - Valid output within four, or two, periods.
// - High beyond 40 ms is on; low seen in 2 ms.
// - Held high with scaling uses 500 Hz internal timer.
// - Code 255 keeps the output always off.
// - Sampling and output use a 10 us step.
// - Battery derating only while disable bit is clear.
// - No derating condition restores full calculated duty.
// - Thermal warning scales duty to 75 percent.
// - Thermal flag sticks until software reads it with the warning gone.
// - Battery and thermal factors multiply; battery 86.
// - Frequency multiplier sits in control bits 2 to 0.
// - Each duty code is a full 8-bit register.
`timescale 1ns/1ps

module ldd_dimmer
	import ldd_pkg::*;
#(
	parameter logic [7:0] DUTY1_DEFAULT = 8'h00,
	parameter logic [7:0] DUTY2_DEFAULT = 8'h00,
	parameter logic [7:0] BATT_DERATE_LVL = 8'h40
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [1:0] dimming_input,
	input wire logic [7:0] battery_supply_pin,
	input wire logic thermal_warning,
	output logic [1:0] buck_enable,
	output logic irq
);

	////////////////////////////////////////////////////////////////////
	// Time base.

	logic [11:0] tick_cnt_q;
	logic tick_q;

	// One pulse every 10 us drives all sampling and output timing.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt_q <= 12'h000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == TICK_LAST);
			tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 12'h000 :
				tick_cnt_q + 12'h001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers for the derating inputs.

	logic therm_s1_q;
	logic therm_s2_q;
	logic therm_d_q;
	logic [7:0] batt_s1_q;
	logic [7:0] batt_s2_q;

	// The battery code varies slowly, so a bitwise crossing is enough;
	// a code caught mid-change only shifts the threshold by one step.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			therm_s1_q <= 1'b0;
			therm_s2_q <= 1'b0;
			therm_d_q <= 1'b0;
			batt_s1_q <= 8'hFF;
			batt_s2_q <= 8'hFF;
		end else begin
			therm_s1_q <= thermal_warning;
			therm_s2_q <= therm_s1_q;
			therm_d_q <= therm_s2_q;
			batt_s1_q <= battery_supply_pin;
			batt_s2_q <= batt_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register file.

	ldd_ctrl_t ctrl_q;
	logic [1:0][7:0] duty_q;
	logic therm_flag_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic irq_q;
	logic batt_act_d_q;

	// An access completes in the cycle where waitrequest is low.
	wire wr_w = avs_write & ~wait_q & avs_byteenable[0];
	wire rd_w = avs_read & ~wait_q;
	wire sel_ctrl = (avs_address == REG_CTRL);
	wire sel_d1 = (avs_address == REG_DUTY1);
	wire sel_d2 = (avs_address == REG_DUTY2);
	wire sel_st = (avs_address == REG_STATUS);
	wire sel_is = (avs_address == REG_IRQ_STAT);
	wire sel_im = (avs_address == REG_IRQ_MASK);

	// Derating conditions, shared by both channels.
	wire batt_act = ~ctrl_q.battery_derate_disable &
		(batt_s2_q < BATT_DERATE_LVL);
	wire therm_act = therm_s2_q;
	wire [6:0] bf_w = batt_act ? PCT_BATTERY : PCT_FULL;
	wire [6:0] tf_w = therm_act ? PCT_THERMAL : PCT_FULL;
	wire therm_rise = therm_s2_q & ~therm_d_q;
	wire batt_rise = batt_act & ~batt_act_d_q;
	wire [1:0] ev_w = {batt_rise, therm_rise};

	// Read data selection; unmapped addresses read as zero.
	wire [31:0] st_w = {29'h0, therm_act, batt_act, therm_flag_q};
	wire [31:0] rmux_w =
		sel_ctrl ? {28'h0, ctrl_q} :
		sel_d1 ? {24'h0, duty_q[0]} :
		sel_d2 ? {24'h0, duty_q[1]} :
		sel_st ? st_w :
		sel_is ? {30'h0, irq_stat_q} :
		sel_im ? {30'h0, irq_mask_q} : 32'h0;

	// Bus handshake: one wait cycle, then the access completes.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0;
		end else begin
			wait_q <= ~((avs_read | avs_write) & wait_q);
			if ((avs_read | avs_write) & wait_q) begin
				rdata_q <= rmux_w;
			end
		end
	end

	// Control and duty codes; duty codes start from their defaults.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
			duty_q <= {DUTY2_DEFAULT, DUTY1_DEFAULT};
		end else if (wr_w) begin
			if (sel_ctrl) begin
				ctrl_q <= avs_writedata[3:0];
			end
			if (sel_d1) begin
				duty_q[0] <= avs_writedata[7:0];
			end
			if (sel_d2) begin
				duty_q[1] <= avs_writedata[7:0];
			end
		end
	end

	// Sticky thermal flag, cleared by a read; a warning still present wins.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			therm_flag_q <= 1'b0;
		end else if (therm_act) begin
			therm_flag_q <= 1'b1;
		end else if (rd_w & sel_st) begin
			therm_flag_q <= 1'b0;
		end
	end

	// Interrupt status is write-one-to-clear, set beats clear.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_stat_q <= IRQ_RESET;
			irq_mask_q <= IRQ_RESET;
			irq_q <= 1'b0;
			batt_act_d_q <= 1'b0;
		end else begin
			batt_act_d_q <= batt_act;
			irq_q <= |(irq_stat_q & irq_mask_q);
			if (wr_w & sel_is) begin
				irq_stat_q <= (irq_stat_q & ~avs_writedata[1:0]) | ev_w;
			end else begin
				irq_stat_q <= irq_stat_q | ev_w;
			end
			if (wr_w & sel_im) begin
				irq_mask_q <= avs_writedata[1:0];
			end
		end
	end

	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdata_q;
	assign irq = irq_q;

	////////////////////////////////////////////////////////////////////
	// Dimming channels.

	// A multiplier of zero is taken as one so the period stays finite.
	wire [2:0] mult_w = (ctrl_q.freq_multiplier == 3'h0) ? 3'h1 :
		ctrl_q.freq_multiplier;
	wire [24:0] den_w = 25'(DUTY_DEN) * {22'h0, mult_w};
	wire [1:0] buck_w;

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_ch
			logic s1_q;
			logic s2_q;
			logic smp_q;
			logic [CNT_W-1:0] run_q;
			logic [CNT_W-1:0] per_q;
			logic [CNT_W-1:0] hi_q;
			logic [CNT_W-1:0] mper_q;
			logic [CNT_W-1:0] mhi_q;
			logic [CNT_W-1:0] ocnt_q;
			logic [CNT_W-1:0] oper_q;
			logic [CNT_W-1:0] ohi_q;
			ldd_mode_t mode_q;
			ldd_mode_t mode_d;
			logic out_q;

			// Each input is sampled once per tick after syncing.
			wire rise = tick_q & s2_q & ~smp_q;
			wire run_max = &run_q;
			wire long_hi = smp_q &
				(run_q >= CNT_W'(LONG_ONE_T));
			wire long_lo = ~smp_q &
				(run_q >= CNT_W'(LONG_ZERO_T));
			wire code_off = (duty_q[i] == DUTY_CODE_MAX);
			wire scaling = (duty_q[i] != 8'h00) | batt_act | therm_act;

			// Held high, the internal timer supplies the period.
			wire [CNT_W-1:0] bper = (mode_q == LDD_ON) ?
				CNT_W'(INT_PER_T) : mper_q;
			wire [CNT_W-1:0] bhi = (mode_q == LDD_ON) ?
				CNT_W'(INT_PER_T) : mhi_q;
			wire [7:0] dfac = DUTY_CODE_MAX - duty_q[i];
			wire [35:0] num = {23'h0, bhi} * {28'h0, dfac} *
				{29'h0, bf_w} * {29'h0, tf_w};
			wire [35:0] hq = num / {11'h0, den_w};
			wire [CNT_W-1:0] tper = bper / CNT_W'(mult_w);
			wire [CNT_W-1:0] thi = hq[CNT_W-1:0];
			wire wrap = tick_q & (ocnt_q + 1'b1 >= oper_q);

			// Input sampler and level run length.
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					smp_q <= 1'b0;
					run_q <= '0;
				end else begin
					s1_q <= dimming_input[i];
					s2_q <= s1_q;
					if (tick_q) begin
						smp_q <= s2_q;
						if (s2_q != smp_q) begin
							run_q <= CNT_W'(1);
						end else if (!run_max) begin
							run_q <= run_q + 1'b1;
						end
					end
				end
			end

			// Period and high time, latched at each rising edge; a duty change
			// skips this latch and shows at the next output period end.
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					per_q <= '0;
					hi_q <= '0;
					mper_q <= '0;
					mhi_q <= '0;
				end else if (rise) begin
					mper_q <= per_q;
					mhi_q <= hi_q;
					per_q <= CNT_W'(1);
					hi_q <= CNT_W'(1);
				end else if (tick_q) begin
					if (!(&per_q)) begin
						per_q <= per_q + 1'b1;
					end
					if (s2_q && !(&hi_q)) begin
						hi_q <= hi_q + 1'b1;
					end
				end
			end

			// Recognition of steady high, steady low, or PWM input.
			always_comb begin
				mode_d = mode_q;
				case (mode_q)
					LDD_OFF: begin
						if (long_hi) begin
							mode_d = LDD_ON;
						end else if (rise) begin
							mode_d = LDD_PWM;
						end
					end
					LDD_PWM: begin
						if (long_hi) begin
							mode_d = LDD_ON;
						end else if (long_lo) begin
							mode_d = LDD_OFF;
						end
					end
					LDD_ON: begin
						if (long_lo) begin
							mode_d = LDD_OFF;
						end else if (rise) begin
							mode_d = LDD_PWM;
						end
					end
					default: begin
						mode_d = LDD_OFF;
					end
				endcase
			end

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					mode_q <= LDD_OFF;
				end else begin
					mode_q <= mode_d;
				end
			end

			// Output period counter; new timing only at period ends.
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					ocnt_q <= '0;
					oper_q <= CNT_W'(1);
					ohi_q <= '0;
				end else if (wrap) begin
					ocnt_q <= '0;
					oper_q <= (tper == '0) ? CNT_W'(1) : tper;
					ohi_q <= thi;
				end else if (tick_q) begin
					ocnt_q <= ocnt_q + 1'b1;
				end
			end

			// A zero factor code or steady low forces the switch off;
			// steady high with no scaling keeps it fully on.
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					out_q <= 1'b0;
				end else if (code_off || mode_q == LDD_OFF) begin
					out_q <= 1'b0;
				end else if (mode_q == LDD_ON && !scaling) begin
					out_q <= 1'b1;
				end else begin
					out_q <= (ocnt_q < ohi_q);
				end
			end

			// Each channel keeps its own flop, so no two processes
			// ever write one variable.
			assign buck_w[i] = out_q;
		end
	endgenerate

	assign buck_enable = buck_w;

endmodule

//--- pkg/ldd_pkg.sv
/*
 * Shared constants and types of the two-channel LED dimming block.
 * Assumes a 200 MHz system clock.
 */
package ldd_pkg;

	// Clock and time base.
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned TICK_US = 10;
	localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);

	// Input level detection times, as tick counts.
	localparam int unsigned LONG_ONE_MS = 40;
	localparam int unsigned LONG_ZERO_MS = 2;
	localparam int unsigned LONG_ONE_T = LONG_ONE_MS * 1000 / TICK_US;
	localparam int unsigned LONG_ZERO_T = LONG_ZERO_MS * 1000 / TICK_US;

	// Internal dimming timer used while the input stays high.
	localparam int unsigned INT_FREQ_HZ = 500;
	localparam int unsigned INT_PER_T = 1_000_000 / (INT_FREQ_HZ * TICK_US);

	// Duty scaling.
	localparam logic [7:0] DUTY_CODE_MAX = 8'hFF;
	localparam logic [6:0] PCT_FULL = 7'd100;
	localparam logic [6:0] PCT_THERMAL = 7'd75;
	localparam logic [6:0] PCT_BATTERY = 7'd86;
	localparam int unsigned DUTY_DEN = 255 * 100 * 100;

	// Tick counter width.
	localparam int unsigned CNT_W = 13;

	// Register byte offsets.
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_DUTY1 = 5'h04;
	localparam logic [4:0] REG_DUTY2 = 5'h08;
	localparam logic [4:0] REG_STATUS = 5'h0C;
	localparam logic [4:0] REG_IRQ_STAT = 5'h10;
	localparam logic [4:0] REG_IRQ_MASK = 5'h14;

	// Field positions.
	localparam int unsigned CTRL_BATT_DIS = 3;
	localparam int unsigned ST_THERM_FLAG = 0;
	localparam int unsigned ST_BATT_ACT = 1;
	localparam int unsigned ST_THERM_ACT = 2;
	localparam int unsigned IRQ_THERM = 0;
	localparam int unsigned IRQ_BATT = 1;

	// Reset values.
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// Control register contents.
	typedef struct packed {
		logic battery_derate_disable;
		logic [2:0] freq_multiplier;
	} ldd_ctrl_t;

	// Input recognition modes of one channel.
	typedef enum logic [2:0] {
		LDD_OFF = 3'b001,
		LDD_PWM = 3'b010,
		LDD_ON = 3'b100
	} ldd_mode_t;

endpackage

//--- verif/ldd_dim_src.sv
/* Model of the outside logic that drives one dimming input pin.
   Assumes per_c and hi_c are set at reset and held. */
`timescale 1ns/1ps
module ldd_dim_src (
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] per_c,
	input wire logic [15:0] hi_c,
	output logic pin
);
	logic [15:0] cnt_q;
	// Free running PWM; a steady period lets the block lock on it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 16'h0000;
			pin <= 1'b0;
		end else begin
			cnt_q <= (cnt_q >= per_c - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
			pin <= (cnt_q < hi_c);
		end
	end
endmodule

//--- verif/ldd_dimmer_props.sv
/* Checker of the dimming block's bus handshake and output step.
   Assumes it is bound to ldd_dimmer and sees only its ports. */
`timescale 1ns/1ps
module ldd_dimmer_props
	import ldd_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [1:0] buck_enable,
	input wire logic irq
);
	logic [11:0] gap_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	// Cycles since the outputs last moved; saturates so it never wraps.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			gap_q <= 12'hFFF;
		else if ($changed(buck_enable))
			gap_q <= 12'h000;
		else if (gap_q != 12'hFFF)
			gap_q <= gap_q + 12'h001;
	end
	////////////////////////////////////////////////////////////////////////
	// Bus handshake, read data and output stepping.
	property p_wait_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	property p_answer;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	property p_idle;
		!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
	endproperty
	property p_cause;
		!avs_waitrequest |-> $past(avs_read || avs_write);
	endproperty
	property p_hold;
		avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata);
	endproperty
	property p_unmap;
		avs_read && !avs_waitrequest && avs_address > REG_IRQ_MASK
			|-> avs_readdata == 32'h0;
	endproperty
	property p_step;
		$changed(buck_enable) |-> gap_q >= TICK_LAST - 12'h001;
	endproperty
	property p_rst;
		$fell(rst) |-> avs_waitrequest && !irq && buck_enable == 2'h0;
	endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("waitrequest low longer than one cycle");
	a_answer: assert property (p_answer)
		else $error("request not answered in one cycle");
	a_idle: assert property (p_idle)
		else $error("waitrequest fell without a request");
	a_cause: assert property (p_cause)
		else $error("answer without a request");
	a_hold: assert property (p_hold)
		else $error("read data moved between accesses");
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
	a_step: assert property (p_step)
		else $error("output moved off the 10 us step");
	a_rst: assert property (p_rst)
		else $error("outputs not idle after reset");
	c_irq: cover property ($rose(irq));
	c_buck: cover property ($rose(buck_enable[0]));
	c_read: cover property (avs_read && !avs_waitrequest);
endmodule

bind ldd_dimmer ldd_dimmer_props u_props (.clk(clk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .buck_enable(buck_enable),
	.irq(irq));

//--- verif/test_led_pwm_dimming_derating.sv
/* Self-checking bench of the dimming block over Avalon-MM.
   Assumes both dimming pins are fed by free running PWM models. */
`timescale 1ns/1ps
module test_led_pwm_dimming_derating
	import ldd_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic wt;
	logic irq;
	logic [1:0] din;
	logic [1:0] be;
	logic [3:0] ben = 4'hF;
	logic [7:0] batt = 8'hFF;
	logic therm = 1'b0;
	logic ch2_on = 1'b0;
	int fail_count = 0;
	int checks = 0;
	////////////////////////////////////////////////////////////////////////
	// Channel 2 runs another waveform so a shared path would show.
	ldd_dimmer uut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_byteenable(ben), .avs_writedata(wd),
		.avs_readdata(rdat), .avs_waitrequest(wt), .dimming_input(din),
		.battery_supply_pin(batt), .thermal_warning(therm),
		.buck_enable(be), .irq(irq));
	ldd_dim_src src1 (.clk(clk), .rst(rst), .per_c(16'h3E80),
		.hi_c(16'h2EE0), .pin(din[0]));
	ldd_dim_src src2 (.clk(clk), .rst(rst), .per_c(16'h2EE0),
		.hi_c(16'h1770), .pin(din[1]));
	initial forever #2.5 clk = ~clk;
	// Channel 2 carries code 0xFF, so any high level is a fault.
	always @(posedge clk) begin
		if (!rst && be[1] !== 1'b0)
			ch2_on <= 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic stop_hang();
		fail_count++;
		$display("mismatch timeout");
		report_and_stop();
	endtask
	// One access; held until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wd <= d;
		rd <= ~w;
		wr <= w;
		do begin
			@(posedge clk);
			n++;
		end while (wt !== 1'b0 && n < 64);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 64)
			stop_hang();
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input string nm, input logic [4:0] a,
		input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, e, q);
	endtask
	// High and period of channel 1 in clocks over one output period.
	// Waiting for a fresh rising edge first lets a change made just
	// before reach a period end, and keeps the run short.
	task automatic step(input logic [31:0] e_hi);
		int n;
		int h;
		int p;
		n = 0;
		h = 0;
		p = 0;
		while (be[0] !== 1'b0 && n < 40000) begin
			@(posedge clk);
			n++;
		end
		while (be[0] !== 1'b1 && n < 40000) begin
			@(posedge clk);
			n++;
		end
		while (be[0] === 1'b1 && n < 40000) begin
			@(posedge clk);
			n++;
			h++;
		end
		while (be[0] === 1'b0 && n < 40000) begin
			@(posedge clk);
			n++;
			p++;
		end
		if (n >= 40000)
			stop_hang();
		chk("high", e_hi, 32'(h));
		chk("period", 32'h1F40, 32'(h + p));
	endtask
	////////////////////////////////////////////////////////////////////////
	// Input is 8 ticks, 6 high, multiplier 2; high is whole ticks.
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd_chk("ctrl", REG_CTRL, 32'h0);
		wr_reg(REG_CTRL, 32'h2);
		wr_reg(REG_DUTY2, 32'hFF);
		rd_chk("ctrl", REG_CTRL, 32'h2);
		rd_chk("duty2", REG_DUTY2, 32'hFF);
		rd_chk("duty1", REG_DUTY1, 32'h0);
		rd_chk("unmapped", 5'h18, 32'h0);
		ben <= 4'h0;
		wr_reg(REG_DUTY1, 32'h55);
		ben <= 4'hF;
		rd_chk("duty1", REG_DUTY1, 32'h0);
		wr_reg(REG_IRQ_MASK, 32'h0);
		step(32'd6000);
		therm <= 1'b1;
		batt <= 8'h00;
		step(32'd2000);
		chk("irq", 32'h0, 32'(irq));
		wr_reg(REG_IRQ_MASK, 32'h1);
		repeat (3) @(posedge clk);
		chk("irq", 32'h1, 32'(irq));
		rd_chk("irq_stat", REG_IRQ_STAT, 32'h3);
		rd_chk("status", REG_STATUS, 32'h7);
		wr_reg(REG_IRQ_STAT, 32'h3);
		repeat (3) @(posedge clk);
		chk("irq", 32'h0, 32'(irq));
		wr_reg(REG_CTRL, 32'hA);
		step(32'd4000);
		rd_chk("status", REG_STATUS, 32'h5);
		therm <= 1'b0;
		batt <= 8'hFF;
		wr_reg(REG_CTRL, 32'h2);
		step(32'd6000);
		rd_chk("status", REG_STATUS, 32'h1);
		rd_chk("status", REG_STATUS, 32'h0);
		chk("ch2", 32'h0, 32'(ch2_on));
		report_and_stop();
	end
endmodule
